// File: clk_startup_pkg.sv
// package of constants and types for the two-speed clock start-up sequencer
package clk_startup_pkg;

  // -------------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------------
  localparam int          ADDR_W            = 4;
  localparam int          DATA_W            = 8;
  localparam logic [3:0]  ADDR_CONFIG       = 4'h0;
  localparam logic [3:0]  ADDR_CONTROL      = 4'h1;
  localparam logic [3:0]  ADDR_STATUS       = 4'h2;
  localparam logic [3:0]  ADDR_IRQ_STATUS   = 4'h3;
  localparam logic [3:0]  ADDR_IRQ_MASK     = 4'h4;

  // config register fields
  localparam int          CFG_OSC_LSB       = 0;
  localparam int          CFG_SWITCH_BIT    = 3;
  localparam int          CFG_DELAY_BIT     = 4;
  localparam logic [7:0]  CFG_RESET         = 8'h00;
  // control register fields
  localparam int          CTL_SEL_LSB       = 0;
  localparam logic [7:0]  CTL_RESET         = 8'h00;
  // status register fields
  localparam int          ST_DONE_BIT       = 0;
  localparam int          ST_EXT_BIT        = 1;
  localparam int          ST_RUN_BIT        = 2;
  localparam int          ST_TWO_SPEED_BIT  = 3;
  // interrupt events
  localparam int          IRQ_N             = 3;
  localparam int          IRQ_DONE          = 0;
  localparam int          IRQ_ABORT         = 1;
  localparam int          IRQ_WARM          = 2;

  // -------------------------------------------------------------------------
  // oscillator configuration codes
  // -------------------------------------------------------------------------
  localparam logic [2:0]  OSC_LOW_POWER     = 3'h0;
  localparam logic [2:0]  OSC_CRYSTAL       = 3'h1;
  localparam logic [2:0]  OSC_HIGH_SPEED    = 3'h2;
  localparam logic [2:0]  OSC_INTERNAL      = 3'h4;
  localparam logic [1:0]  SEL_CONFIG        = 2'h0;
  localparam logic [1:0]  SEL_SECONDARY     = 2'h1;
  localparam logic [1:0]  SEL_INTERNAL      = 2'h2;

  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam int          QUAL_COUNT        = 1024;
  localparam int          CLK_MHZ           = 25;
  localparam int          WARM_US           = 2;
  localparam int          WARM_CYCLES       = WARM_US * CLK_MHZ;
  localparam int          POWERUP_MS        = 64;
  localparam int          POWERUP_CYCLES    = POWERUP_MS * 1000 * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_RESET, ST_POWERUP, ST_INTERNAL, ST_HOLD, ST_EXTERNAL, ST_SLEEP, ST_WARM
  } seq_state_t;

endpackage : clk_startup_pkg

// File: crystal_osc_model.sv
// behavioural external crystal that gives one tick per oscillation
`timescale 1ns/100ps
module crystal_osc_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       run,
  input  wire logic [3:0] div,
  output logic            osc_tick
);
  logic [3:0] cnt_q;

  // ---------------------------------------------------------------------------
  // oscillation
  // ---------------------------------------------------------------------------
  // a stopped crystal gives no ticks at all, so a stalled qualification can be
  // provoked; div 0 ticks every cycle, larger values model a slow crystal
  always_ff @(posedge clk) begin
    if (sys_rst || !run) begin
      cnt_q    <= 4'h0;
      osc_tick <= 1'b0;
    end else begin
      cnt_q    <= (cnt_q >= div) ? 4'h0 : cnt_q + 4'h1;
      osc_tick <= (cnt_q >= div);
    end
  end
endmodule : crystal_osc_model

// File: delay_timer.sv
// one-shot cycle delay timer for warm-up and power-up intervals
`timescale 1ns/100ps
module delay_timer #(
  parameter int CYCLES = 50
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic start,
  output logic      expired
);
  logic [$clog2(CYCLES+1)-1:0] cnt_q;

  always_ff @(posedge clk) begin
    if (sys_rst || start) begin
      cnt_q <= '0;
    end else if (!expired) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign expired = (cnt_q == ($clog2(CYCLES+1))'(CYCLES));
endmodule : delay_timer

// File: osc_startup_counter.sv
// counter of external oscillator edges qualifying the crystal
`timescale 1ns/100ps
module osc_startup_counter #(
  parameter int COUNT = 1024
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic clear,
  input  wire logic enable,
  input  wire logic osc_tick,
  output logic      done
);
  logic [$clog2(COUNT+1)-1:0] cnt_q;

  always_ff @(posedge clk) begin
    if (sys_rst || clear) begin
      cnt_q <= '0;
    end else if (enable && osc_tick && !done) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign done = (cnt_q == ($clog2(COUNT+1))'(COUNT));

  AST_COUNT_CAP: assert property (@(posedge clk) disable iff (sys_rst)
    done && !clear |=> done) else $error("counter left done without clear");
endmodule : osc_startup_counter

// File: two_speed_clock_startup.sv
// two-speed clock start-up sequencer with register port and interrupt
`timescale 1ns/100ps
module two_speed_clock_startup
  import clk_startup_pkg::*;
#(
  parameter int POWERUP_CYC = clk_startup_pkg::POWERUP_CYCLES,
  parameter int QUAL_CNT    = clk_startup_pkg::QUAL_COUNT
) (
  input  wire logic                              clk,
  input  wire logic                              sys_rst,
  input  wire logic                              por_event,
  input  wire logic                              brownout_reset,
  input  wire logic                              ext_osc_tick,
  input  wire logic                              sleep_req,
  input  wire logic                              wake_req,
  input  wire logic [clk_startup_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [clk_startup_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  output logic      [clk_startup_pkg::DATA_W-1:0] reg_rdata,
  output logic                                   sel_internal_osc,
  output logic                                   sel_external_osc,
  output logic                                   cpu_run,
  output logic                                   in_sleep,
  output logic                                   irq
);
  import clk_startup_pkg::*;

  // -------------------------------------------------------------------------
  // registers and decode
  // -------------------------------------------------------------------------
  logic [7:0]       cfg_q;
  logic [7:0]       ctl_q;
  logic [IRQ_N-1:0] irq_st_q;
  logic [IRQ_N-1:0] irq_mask_q;
  logic             done_flag_q;
  seq_state_t       state_q;
  seq_state_t       state_d;
  logic             ext_q;

  wire wr_cfg   = reg_wr && (reg_addr == ADDR_CONFIG);
  wire wr_ctl   = reg_wr && (reg_addr == ADDR_CONTROL);
  wire wr_ist   = reg_wr && (reg_addr == ADDR_IRQ_STATUS);
  wire wr_imask = reg_wr && (reg_addr == ADDR_IRQ_MASK);

  wire [2:0] osc_config_field   = cfg_q[CFG_OSC_LSB +: 3];
  wire       switchover_enable  = cfg_q[CFG_SWITCH_BIT];
  wire       powerup_enable     = cfg_q[CFG_DELAY_BIT];
  wire [1:0] clock_select_field = ctl_q[CTL_SEL_LSB +: 2];

  wire crystal_cfg = (osc_config_field == OSC_LOW_POWER) ||
                     (osc_config_field == OSC_CRYSTAL) ||
                     (osc_config_field == OSC_HIGH_SPEED);
  wire internal_target = (clock_select_field == SEL_INTERNAL) ||
                         (!crystal_cfg && clock_select_field == SEL_CONFIG &&
                          osc_config_field == OSC_INTERNAL);
  wire needs_qual = crystal_cfg || (clock_select_field == SEL_SECONDARY);
  // two-speed only with all three conditions; non-crystal drops it
  wire two_speed = switchover_enable && (clock_select_field == SEL_CONFIG) &&
                   crystal_cfg;

  // -------------------------------------------------------------------------
  // timers
  // -------------------------------------------------------------------------
  logic qual_done;
  logic warm_done;
  logic powerup_done;
  logic qual_clear;
  logic warm_start;
  logic powerup_start;
  logic qualifying;

  // counter restarts on every entry to a start-up, runs in crystal modes
  assign qual_clear = (state_q != state_d) &&
                      (state_d == ST_INTERNAL || state_d == ST_HOLD);
  assign qualifying = (state_q == ST_INTERNAL) || (state_q == ST_HOLD);
  assign warm_start = (state_q != ST_WARM) && (state_d == ST_WARM);
  // brown-out and power-on both restart the power-up delay
  assign powerup_start = por_event || brownout_reset;

  osc_startup_counter #(.COUNT(QUAL_CNT)) u_qual (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clear    (qual_clear),
    .enable   (qualifying && needs_qual),
    .osc_tick (ext_osc_tick),
    .done     (qual_done)
  );

  delay_timer #(.CYCLES(WARM_CYCLES)) u_warm (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (warm_start),
    .expired (warm_done)
  );

  delay_timer #(.CYCLES(POWERUP_CYC)) u_powerup (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (powerup_start),
    .expired (powerup_done)
  );

  // -------------------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------------------
  // full state width; a plain wire would keep only one bit of the target
  seq_state_t startup_target;
  assign startup_target = internal_target ? ST_WARM :
                          (!needs_qual ? ST_EXTERNAL :
                          (two_speed ? ST_INTERNAL : ST_HOLD));

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RESET: begin
        // power-up delay is optional; start-up sequence follows it
        state_d = powerup_enable ? ST_POWERUP : seq_state_t'(startup_target);
      end
      ST_POWERUP: begin
        if (powerup_done) begin
          state_d = seq_state_t'(startup_target);
        end
      end
      ST_INTERNAL, ST_HOLD: begin
        if (sleep_req) begin
          state_d = ST_SLEEP;
        end else if (qual_done) begin
          state_d = ST_EXTERNAL;
        end
      end
      ST_EXTERNAL: begin
        if (sleep_req) begin
          state_d = ST_SLEEP;
        end
      end
      ST_WARM: begin
        if (warm_done) begin
          state_d = ST_EXTERNAL;
        end
      end
      ST_SLEEP: begin
        if (wake_req) begin
          state_d = seq_state_t'(startup_target);
        end
      end
      default: state_d = ST_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst || por_event || brownout_reset) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // flag cleared on reset, on entry to qualification or on sleep abort, set only when the count completes
  always_ff @(posedge clk) begin
    if (sys_rst || por_event || brownout_reset) begin
      done_flag_q <= 1'b0;
    end else if (qualifying && state_d == ST_EXTERNAL) begin
      done_flag_q <= 1'b1;
    end else if (qual_clear || state_d == ST_SLEEP && qualifying) begin
      done_flag_q <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // clock selection outputs
  // -------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_internal_osc <= 1'b1;
      sel_external_osc <= 1'b0;
      cpu_run          <= 1'b0;
      in_sleep         <= 1'b0;
      ext_q            <= 1'b0;
    end else begin
      // internal block keeps code running while the crystal qualifies in ST_INTERNAL (two-speed) only
      sel_internal_osc <= (state_d == ST_INTERNAL) || internal_target;
      sel_external_osc <= (state_d == ST_EXTERNAL) && !internal_target;
      // hold execution when two-speed is off and counter still running
      cpu_run          <= (state_d == ST_INTERNAL) || (state_d == ST_EXTERNAL);
      in_sleep         <= (state_d == ST_SLEEP);
      ext_q            <= (state_d == ST_EXTERNAL);
    end
  end

  // -------------------------------------------------------------------------
  // register file and interrupt
  // -------------------------------------------------------------------------
  logic [IRQ_N-1:0] ev;
  assign ev[IRQ_DONE]  = qualifying && (state_d == ST_EXTERNAL);
  assign ev[IRQ_ABORT] = qualifying && (state_d == ST_SLEEP);
  assign ev[IRQ_WARM]  = (state_q == ST_WARM) && warm_done;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_q <= CFG_RESET;
      ctl_q <= CTL_RESET;
      irq_mask_q <= '0;
    end else begin
      if (wr_cfg) cfg_q <= reg_wdata;
      if (wr_ctl) ctl_q <= reg_wdata;
      if (wr_imask) irq_mask_q <= reg_wdata[IRQ_N-1:0];
    end
  end

  // set wins over write-one-to-clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_st_q <= '0;
    end else begin
      irq_st_q <= (irq_st_q & ~(wr_ist ? reg_wdata[IRQ_N-1:0] : '0)) | ev;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_st_q & ~(wr_ist ? reg_wdata[IRQ_N-1:0] : '0)) | ev) & irq_mask_q);
    end
  end

  wire [7:0] status_word = {4'h0, two_speed, cpu_run, ext_q, done_flag_q};
  wire [7:0] rd_mux = (reg_addr == ADDR_CONFIG)     ? cfg_q :
                      (reg_addr == ADDR_CONTROL)    ? ctl_q :
                      (reg_addr == ADDR_STATUS)     ? status_word :
                      (reg_addr == ADDR_IRQ_STATUS) ? {5'h00, irq_st_q} :
                      (reg_addr == ADDR_IRQ_MASK)   ? {5'h00, irq_mask_q} : 8'h00;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  AST_EXT_NEEDS_COUNT: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(ext_q) && crystal_cfg && !internal_target |-> done_flag_q || !two_speed
    ) else $error("external clock taken without qualification");
  AST_DONE_SETS_FLAG: assert property (@(posedge clk) disable iff (sys_rst || por_event)
    qualifying && qual_done && !sleep_req |=> done_flag_q && ext_q
    ) else $error("done count did not switch");
  AST_SLEEP_ABORT: assert property (@(posedge clk) disable iff (sys_rst || por_event)
    qualifying && sleep_req |=> !done_flag_q && in_sleep
    ) else $error("sleep did not abort qualification");
  AST_INTERNAL_RUNS: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == ST_INTERNAL |-> sel_internal_osc && cpu_run
    ) else $error("no internal clock while qualifying");
  AST_HOLD_STOPS: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == ST_HOLD |-> !cpu_run
    ) else $error("execution not held");
  AST_TWO_SPEED_GATE: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == ST_INTERNAL && !$changed(cfg_q) && !$changed(ctl_q) |-> two_speed
    ) else $error("two-speed used when not enabled");
  AST_WAKE_ENTERS: assert property (@(posedge clk) disable iff (sys_rst || por_event)
    state_q == ST_SLEEP && wake_req && two_speed |=> state_q == ST_INTERNAL
    ) else $error("wake did not enter two-speed start-up");
  AST_WARM_WAIT: assert property (@(posedge clk) disable iff (sys_rst || por_event)
    state_q == ST_WARM && !warm_done |=> !ext_q
    ) else $error("internal clock used before warm-up");
  AST_COUNTER_RUNS: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(ext_q) && $past(qualifying) |-> $past(qual_done)
    ) else $error("external clock taken before count done");
  AST_POWERUP_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == ST_POWERUP |-> !cpu_run
    ) else $error("running during power-up delay");
endmodule : two_speed_clock_startup

// File: two_speed_clock_startup_tb.sv
// self-checking testbench of the two-speed clock start-up sequencer
`timescale 1ns/100ps
module two_speed_clock_startup_tb;
  import clk_startup_pkg::*;
  localparam int POWERUP_SIM = 20;
  localparam int QUAL_SIM    = 8;
  logic              clk, sys_rst, por_event, brownout_reset, sleep_req, wake_req;
  logic              reg_wr, reg_rd, osc_run, ext_osc_tick;
  logic              sel_internal_osc, sel_external_osc, cpu_run, in_sleep, irq;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, v;
  logic [3:0]        osc_div;
  wire  [3:0]        outs = {irq, in_sleep, sel_external_osc, cpu_run};
  int                fail_count, total_checks, tick_cnt, n;

  crystal_osc_model osc (.clk(clk), .sys_rst(sys_rst), .run(osc_run), .div(osc_div),
                         .osc_tick(ext_osc_tick));
  two_speed_clock_startup #(.POWERUP_CYC(POWERUP_SIM), .QUAL_CNT(QUAL_SIM)) dut (
    .clk(clk), .sys_rst(sys_rst), .por_event(por_event), .brownout_reset(brownout_reset),
    .ext_osc_tick(ext_osc_tick), .sleep_req(sleep_req), .wake_req(wake_req),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sel_internal_osc(sel_internal_osc),
    .sel_external_osc(sel_external_osc), .cpu_run(cpu_run), .in_sleep(in_sleep), .irq(irq));

  // ---------------------------------------------------------------------------
  // clock, tick tally, watchdog
  // ---------------------------------------------------------------------------
  initial clk = 1'b0;
  always #20 clk = ~clk;
  // tally is cleared only while the crystal is stopped, so no edge race
  always @(posedge clk) if (ext_osc_tick) tick_cnt <= tick_cnt + 1;
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report();
  end

  // ---------------------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr
  // read data is taken at the edge after the strobe, before it is cleared
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    v = reg_rdata;
  endtask : rd
  task automatic restart(input logic bo);
    if (bo) brownout_reset <= 1'b1;
    else por_event <= 1'b1;
    @(posedge clk);
    por_event      <= 1'b0;
    brownout_reset <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : restart
  task automatic ev(input logic slp);
    if (slp) sleep_req <= 1'b1;
    else wake_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    wake_req  <= 1'b0;
    @(posedge clk);
  endtask : ev
  task automatic wait_out(input int sel, input int lim);
    n = 0;
    while (outs[sel] !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      $display("BAD t=%0t wait on output %0d timed out", $time, sel);
    end
  endtask : wait_out
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    {sys_rst, por_event, brownout_reset, sleep_req, wake_req, reg_wr, reg_rd} = 7'h40;
    {osc_run, osc_div, reg_addr, reg_wdata, tick_cnt} = '0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk({3'h0, sel_internal_osc, outs}, 8'h10);
    rd(ADDR_CONFIG);    chk(v, CFG_RESET);
    rd(ADDR_CONTROL);   chk(v, CTL_RESET);
    rd(ADDR_IRQ_MASK);  chk(v, 8'h00);
    wr(4'h5, 8'hff);
    rd(4'h5);           chk(v, 8'h00);
    rd(ADDR_STATUS);    chk(v, 8'h00);
    repeat (40) @(posedge clk);
    chk({7'h0, cpu_run}, 8'h00);
    osc_div <= 4'h3;
    osc_run <= 1'b1;
    wait_out(1, 300);
    chk({7'h0, tick_cnt >= QUAL_SIM}, 8'h01);
    chk({6'h0, outs[1:0]}, 8'h03);
    rd(ADDR_STATUS);    chk(v & 8'h07, 8'h07);
    wr(ADDR_IRQ_STATUS, 8'hff);
    // two-speed start-up from power-on with crystal mode
    osc_run <= 1'b0;
    wr(ADDR_CONFIG, 8'h08 | OSC_CRYSTAL);
    wr(ADDR_IRQ_MASK, 8'h07);
    restart(1'b0);
    tick_cnt = 0;
    wait_out(0, 20);
    chk({6'h0, sel_internal_osc, sel_external_osc}, 8'h02);
    rd(ADDR_STATUS);    chk(v, 8'h0c);
    osc_run <= 1'b1;
    wait_out(1, 300);
    chk({7'h0, tick_cnt >= QUAL_SIM}, 8'h01);
    chk({7'h0, sel_internal_osc}, 8'h00);
    rd(ADDR_STATUS);    chk(v & 8'h03, 8'h03);
    wait_out(3, 4);
    rd(ADDR_IRQ_STATUS); chk(v, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h07);
    wr(ADDR_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    rd(ADDR_IRQ_STATUS); chk(v, 8'h00);
    // sleep in mid-qualification with a slow crystal, then wake
    osc_run <= 1'b0;
    osc_div <= 4'hf;
    restart(1'b0);
    wait_out(0, 20);
    osc_run <= 1'b1;
    repeat (20) @(posedge clk);
    ev(1'b1);
    wait_out(2, 4);
    rd(ADDR_STATUS);    chk(v & 8'h01, 8'h00);
    rd(ADDR_IRQ_STATUS); chk(v & 8'h02, 8'h02);
    chk({7'h0, irq}, 8'h01);
    osc_run <= 1'b0;
    wr(ADDR_IRQ_STATUS, 8'hff);
    ev(1'b0);
    tick_cnt = 0;
    wait_out(0, 20);
    chk({6'h0, sel_internal_osc, in_sleep}, 8'h02);
    osc_div <= 4'h0;
    osc_run <= 1'b1;
    wait_out(1, 100);
    chk({7'h0, tick_cnt >= QUAL_SIM}, 8'h01);
    // every oscillator code, crystal stopped
    osc_run <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_CONFIG, 8'h08 | 8'(c));
      restart(1'b0);
      wait_out(0, 100);
      rd(ADDR_STATUS);  chk({7'h0, v[ST_TWO_SPEED_BIT]}, {7'h0, c < 3});
    end
    for (int s = 1; s < 3; s++) begin
      wr(ADDR_CONFIG, 8'h08 | OSC_CRYSTAL);
      wr(ADDR_CONTROL, 8'(s));
      restart(1'b0);
      repeat (30) @(posedge clk);
      rd(ADDR_STATUS);  chk({7'h0, v[ST_TWO_SPEED_BIT]}, 8'h00);
    end
    wr(ADDR_CONTROL, 8'h00);
    // wake toward the internal oscillator needs the warm-up delay
    wr(ADDR_CONFIG, 8'h08 | OSC_INTERNAL);
    restart(1'b0);
    wait_out(0, 100);
    ev(1'b1);
    wait_out(2, 4);
    wr(ADDR_IRQ_STATUS, 8'hff);
    ev(1'b0);
    wait_out(0, 200);
    chk({7'h0, n >= 40 && n <= 60}, 8'h01);
    rd(ADDR_IRQ_STATUS); chk(v & 8'h04, 8'h04);
    // power-up delay after brown-out and power-on events
    wr(ADDR_CONFIG, 8'h18 | OSC_CRYSTAL);
    for (int b = 1; b >= 0; b--) begin
      restart(b[0]);
      repeat (10) @(posedge clk);
      chk({7'h0, cpu_run}, 8'h00);
      wait_out(0, 60);
    end
    final_report();
  end
endmodule : two_speed_clock_startup_tb
